// *** logic/rf_cfg_pkg.sv ***
// constants for the rf configuration register bank
package rf_cfg_pkg;
  // register addresses on the serial control port
  localparam logic [7:0] channel_select_addr   = 8'h21;
  localparam logic [7:0] signal_strength_addr  = 8'h22;
  localparam logic [7:0] tx_power_control_addr = 8'h23;
  localparam logic [7:0] crystal_trim_addr     = 8'h24;
  localparam logic [7:0] oscillator_slope_addr = 8'h26;
  // reset values
  localparam logic [7:0] channel_select_rst    = 8'h00;
  localparam logic [7:0] signal_strength_rst   = 8'h00;
  localparam logic [7:0] tx_power_control_rst  = 8'h00;
  localparam logic [7:0] crystal_trim_rst      = 8'h00;
  localparam logic [7:0] oscillator_slope_rst  = 8'h00;
  // field positions
  localparam int src_select_bit   = 7;
  localparam int strength_valid_bit = 5;
  localparam int clock_off_bit    = 6;
  localparam int slope_lsb        = 6;
  // channel to frequency: base (MHz) for channel 0, step in MHz
  localparam logic [11:0] chan_base_mhz = 12'h961; // 2401 MHz
  localparam logic [11:0] chan_step_mhz = 12'h001;
  // oscillator slope codes
  typedef enum logic [1:0] {
    slope_none     = 2'h0,
    slope_reserved = 2'h1,
    slope_m2_p3    = 2'h2,
    slope_m5_p5    = 2'h3
  } slope_type;
endpackage : rf_cfg_pkg

// *** logic/strength_capture.sv ***
// single-sample signal strength capture on receive entry
`timescale 1ns/100ps
module strength_capture (
  input  wire logic       clk,         // reference clock
  input  wire logic       rst,         // async reset, active high
  input  wire logic       rx_enter,    // pulse: receive mode entered
  input  wire logic       meas_valid,  // measurement ready strobe
  input  wire logic [4:0] meas_value,  // raw strength measurement
  output logic      [7:0] strength_q   // packed register value
);
  logic armed_q;

  // one sample per receive entry; later strobes are ignored
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      armed_q    <= 1'b0;
      strength_q <= rf_cfg_pkg::signal_strength_rst;
    end
    else if (rx_enter)
    begin
      armed_q    <= 1'b1;
      strength_q <= rf_cfg_pkg::signal_strength_rst;
    end
    else if (armed_q && meas_valid)
    begin
      armed_q    <= 1'b0;
      strength_q <= {2'h0, 1'b1, meas_value};
    end
  end
endmodule : strength_capture

// *** logic/rf_config_regs.sv ***
// rf configuration register bank behind the serial control port
`timescale 1ns/100ps
// Notes on behaviour
// - with source select set, frequency comes from the two counter values.
// - with source select clear, frequency comes from the channel field.
// - channel n maps to 2401+n MHz in 1 MHz steps.
// - strength register is read-only, bit 5 flags a valid value.
// - strength is a five-bit value, larger means stronger.
// - at most one strength sample is taken per receive-mode entry.
// - the three-bit amplifier level sets transmit power, higher is more.
// - crystal bit 6 set stops the reference clock output, clear drives it.
// - the six-bit trim field sets crystal load capacitance.
// - slope code 11 is -5/+5, 10 is -2/+3, 01 reserved, 00 none.
// - reads of the slope field return an undefined value, here zero.
module rf_config_regs (
  input  wire logic        clk,              // reference clock
  input  wire logic        rst,              // async reset, active high
  input  wire logic        reg_wr,           // register write strobe
  input  wire logic        reg_rd,           // register read strobe
  input  wire logic [7:0]  reg_addr,         // register address
  input  wire logic [7:0]  reg_wdata,        // write data
  input  wire logic [7:0]  counter_a,        // synth a counter value
  input  wire logic [7:0]  counter_n,        // synth n counter value
  input  wire logic        rx_enter,         // receive mode entry pulse
  input  wire logic        meas_valid,       // strength measurement strobe
  input  wire logic [4:0]  meas_value,       // strength measurement
  input  wire logic        ref_clock_in,     // divided reference clock
  output logic      [7:0]  reg_rdata,        // read data, registered
  output logic             use_counters,     // synth uses a/n counters
  output logic      [11:0] synth_freq_mhz,   // channel frequency in mhz
  output logic      [15:0] synth_counters,   // {n, a} counter values
  output logic      [2:0]  tx_amp_level,     // amplifier bias level
  output logic      [5:0]  crystal_load,     // crystal load trim
  output logic             ref_clock_out_pin,// reference clock output
  output logic      [1:0]  oscillator_slope_code, // slope adjust code
  output logic             slope_adjust_on   // slope adjust active
);
  logic [7:0] channel_q;
  logic [7:0] power_q;
  logic [7:0] crystal_q;
  logic [1:0] slope_q;
  logic [7:0] strength_q;
  logic       wr_channel;  // write hits the channel register
  logic       wr_power;    // write hits the power register
  logic       wr_crystal;  // write hits the crystal register
  logic       wr_slope;    // write hits the slope register

  // --------------------------------------------------------------------
  // writable registers
  // --------------------------------------------------------------------
  // one strobe per writable register; the strength address and unmapped
  // addresses raise none, so such writes fall through untouched
  // strength write ignored
  always_comb
  begin
    wr_channel = 1'b0;
    wr_power   = 1'b0;
    wr_crystal = 1'b0;
    wr_slope   = 1'b0;
    if (reg_wr)
    begin
      if (reg_addr == rf_cfg_pkg::channel_select_addr)
        wr_channel = 1'b1;
      else if (reg_addr == rf_cfg_pkg::tx_power_control_addr)
        wr_power = 1'b1;
      else if (reg_addr == rf_cfg_pkg::crystal_trim_addr)
        wr_crystal = 1'b1;
      else if (reg_addr == rf_cfg_pkg::oscillator_slope_addr)
        wr_slope = 1'b1;
    end
  end

  // channel register keeps all eight bits, source select included
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      channel_q <= rf_cfg_pkg::channel_select_rst;
    else if (wr_channel)
      channel_q <= reg_wdata;
  end

  // reserved bits stored as zero so reads never echo stray host bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      power_q <= rf_cfg_pkg::tx_power_control_rst;
    else if (wr_power)
      power_q <= {5'h00, reg_wdata[2:0]};
  end

  // crystal register, reserved top bit held at zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crystal_q <= rf_cfg_pkg::crystal_trim_rst;
    else if (wr_crystal)
      crystal_q <= {1'b0, reg_wdata[6:0]};
  end

  // only the slope field is kept; the rest of the byte is reserved
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      slope_q <= rf_cfg_pkg::oscillator_slope_rst[7:6];
    else if (wr_slope)
      slope_q <= reg_wdata[rf_cfg_pkg::slope_lsb +: 2];
  end

  // --------------------------------------------------------------------
  // signal strength capture
  // --------------------------------------------------------------------
  // one sample per entry
  strength_capture strength_capture_i (
    .clk        (clk),
    .rst        (rst),
    .rx_enter   (rx_enter),
    .meas_valid (meas_valid),
    .meas_value (meas_value),
    .strength_q (strength_q)
  );

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  // read data held until the next read; unmapped reads give zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == rf_cfg_pkg::channel_select_addr)
        reg_rdata <= channel_q;
      else if (reg_addr == rf_cfg_pkg::signal_strength_addr)
        reg_rdata <= strength_q;
      else if (reg_addr == rf_cfg_pkg::tx_power_control_addr)
        reg_rdata <= power_q;
      else if (reg_addr == rf_cfg_pkg::crystal_trim_addr)
        reg_rdata <= crystal_q;
      else
        reg_rdata <= 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // synthesizer selection
  // --------------------------------------------------------------------
  // both paths are registered so the synthesizer sees one clean choice
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      use_counters   <= 1'b0;
      synth_freq_mhz <= 12'h000;
      synth_counters <= 16'h0000;
    end
    else
    begin
      use_counters <= channel_q[rf_cfg_pkg::src_select_bit];
      if (channel_q[rf_cfg_pkg::src_select_bit])
      begin
        synth_counters <= {counter_n, counter_a};
        synth_freq_mhz <= 12'h000;
      end
      else
      begin
        synth_counters <= 16'h0000;
        synth_freq_mhz <= rf_cfg_pkg::chan_base_mhz
                        + rf_cfg_pkg::chan_step_mhz
                        * {5'h00, channel_q[6:0]};
      end
    end
  end

  // --------------------------------------------------------------------
  // analog control outputs
  // --------------------------------------------------------------------
  // each control leaves through its own flop, one edge behind its register
  // amplifier level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tx_amp_level <= 3'h0;
    else
      tx_amp_level <= power_q[2:0];
  end

  // trim follows the stored field one edge later
  // load trim
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crystal_load <= 6'h00;
    else
      crystal_load <= crystal_q[5:0];
  end

  // clock gate through a flop adds one cycle of delay; harmless for a pin
  // clock output gate
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ref_clock_out_pin <= 1'b0;
    else
      ref_clock_out_pin <= ref_clock_in
                           & ~crystal_q[rf_cfg_pkg::clock_off_bit];
  end

  // reserved code 01 passes through but leaves adjustment off
  // slope decode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      oscillator_slope_code <= 2'h0;
      slope_adjust_on       <= 1'b0;
    end
    else
    begin
      oscillator_slope_code <= slope_q;
      slope_adjust_on       <= (slope_q == rf_cfg_pkg::slope_m5_p5)
                            || (slope_q == rf_cfg_pkg::slope_m2_p3);
    end
  end
endmodule : rf_config_regs

// *** bench/rf_host.sv ***
// host model speaking the register strobe protocol
`timescale 1ns/100ps
module rf_host (
  input  wire logic       clk,       // reference clock
  input  wire logic [7:0] reg_rdata, // read data
  output logic            reg_wr,    // write strobe
  output logic            reg_rd,    // read strobe
  output logic      [7:0] reg_addr,  // address
  output logic      [7:0] reg_wdata  // write data
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // callers pass reserved bits as zero, save the 8'hFF write to the read-only strength register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk) #1;
    // released lines invert, so a stale value never looks valid
    {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk) #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk) #1;
    q = reg_rdata;
    {reg_rd, reg_addr} = {1'b0, ~a};
  endtask : rd
endmodule : rf_host

// *** bench/rf_cfg_chk.sv ***
// port assertions for the rf config registers
`timescale 1ns/100ps
module rf_cfg_chk (
  input wire logic        clk,   // clock
  input wire logic        rst,   // reset
  input wire logic        reg_wr, // write
  input wire logic        reg_rd, // read
  input wire logic [7:0]  reg_addr, // address
  input wire logic [7:0]  reg_wdata, // wdata
  input wire logic [7:0]  reg_rdata, // rdata
  input wire logic        use_counters, // mode
  input wire logic [11:0] synth_freq_mhz, // freq
  input wire logic [15:0] synth_counters, // counters
  input wire logic [2:0]  tx_amp_level, // amp
  input wire logic [5:0]  crystal_load, // trim
  input wire logic        ref_clock_out_pin, // clock out
  input wire logic [1:0]  oscillator_slope_code, // slope
  input wire logic        slope_adjust_on // slope on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // write decodes, outputs land two edges later
  wire w21 = reg_wr && reg_addr == 8'h21;
  wire w23 = reg_wr && reg_addr == 8'h23;
  wire w24 = reg_wr && reg_addr == 8'h24;
  wire w26 = reg_wr && reg_addr == 8'h26;
  a_count_src:
  assert property (use_counters |-> synth_freq_mhz == 12'h000)
    else $error("frequency set in counter mode");
  a_chan_src:
  assert property (!use_counters |-> synth_counters == 16'h0000)
    else $error("counters set in channel mode");
  a_chan_map:
  assert property (w21 && !reg_wdata[7] |-> ##2
    synth_freq_mhz == 12'h961 + $past(reg_wdata[6:0], 2))
    else $error("wrong channel frequency");
  a_amp_lvl:
  assert property (w23 |-> ##2 tx_amp_level == $past(reg_wdata[2:0], 2))
    else $error("wrong amplifier level");
  a_clk_off:
  assert property (w24 && reg_wdata[6] |-> ##2 !ref_clock_out_pin)
    else $error("clock output not stopped");
  a_trim_val:
  assert property (w24 |-> ##2 crystal_load == $past(reg_wdata[5:0], 2))
    else $error("wrong crystal trim");
  a_slope_dec:
  assert property (w26 |-> ##2 oscillator_slope_code == $past(reg_wdata[7:6],
    2) && slope_adjust_on == $past(reg_wdata[7], 2))
    else $error("wrong slope decode");
  a_rssi_rsvd:
  assert property (reg_rd && reg_addr == 8'h22 |=> reg_rdata[7:6] == 2'h0)
    else $error("strength reserved bits set");
endmodule : rf_cfg_chk
bind rf_config_regs rf_cfg_chk rf_cfg_chk_i (.clk, .rst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .use_counters, .synth_freq_mhz,
  .synth_counters, .tx_amp_level, .crystal_load, .ref_clock_out_pin,
  .oscillator_slope_code, .slope_adjust_on);

// *** bench/rf_config_regs_tb.sv ***
// self-checking bench for the rf config registers
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module rf_config_regs_tb;
  logic clk = 0, rst = 1, rx_enter = 0, meas_valid = 0, ref_clock_in = 0, p;
  logic [7:0] counter_a = 8'h00, counter_n = 8'h00, q, reg_addr, reg_wdata;
  logic [4:0] meas_value = 5'h00;
  logic [7:0] reg_rdata, chs [4] = '{8'h01, 8'h4F, 8'h7F, 8'h05};
  logic reg_wr, reg_rd, use_counters, ref_clock_out_pin, slope_adjust_on;
  logic [11:0] synth_freq_mhz;
  logic [15:0] synth_counters;
  logic [2:0]  tx_amp_level;
  logic [5:0]  crystal_load;
  logic [1:0]  oscillator_slope_code;
  int n_fail = 0, checks_done = 0, cyc = 0;
  rf_config_regs rf_config_regs_i (.*);
  rf_host rf_host_i (.*);
  always #5 clk = ~clk;
  always @(posedge clk) ref_clock_in <= #1 ~ref_clock_in;
  // hang guard, the run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rf_host_i.wr(a, d);
    @(posedge clk) #1;
  endtask : wr
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    rf_host_i.rd(a, q);
    `CHK(n, e, q)
  endtask : rc
  task automatic pulse(ref logic s);
    @(posedge clk) #1 s = 1;
    @(posedge clk) #1 s = 0;
  endtask : pulse
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    rc("chan", 8'h21, 8'h00);
    rc("pwr", 8'h23, 8'h00);
    p = ref_clock_out_pin;
    @(posedge clk) #1;
    `CHK("clkout", 1'b1, p ^ ref_clock_out_pin)
    counter_a = 8'h3C;
    counter_n = 8'hA5;
    wr(8'h21, 8'h85);
    `CHK("src", 1'b1, use_counters)
    `CHK("cnt", 16'hA53C, synth_counters)
    rc("chan_rb", 8'h21, 8'h85);
    // channel mode is left in use
    foreach (chs[i])
    begin
      wr(8'h21, chs[i]);
      `CHK("freq", 12'h961 + chs[i], synth_freq_mhz)
      `CHK("cnt0", 16'h0000, synth_counters)
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h23, 8'(i));
      `CHK("amp", 3'(i), tx_amp_level)
    end
    // clock output turned off once the trim is set
    wr(8'h24, 8'h55);
    `CHK("trim", 6'h15, crystal_load)
    `CHK("clkoff", 1'b0, ref_clock_out_pin)
    // last slope code written is 11
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h26, {2'(i), 6'h00});
      `CHK("slope", 2'(i), oscillator_slope_code)
      `CHK("adj", i[1], slope_adjust_on)
    end
    rc("slope_rd", 8'h26, 8'h00);
    meas_value = 5'h1A;
    pulse(rx_enter);
    pulse(meas_valid);
    rc("rssi", 8'h22, 8'h3A);
    meas_value = 5'h05;
    pulse(meas_valid);
    rc("rssi2", 8'h22, 8'h3A);
    wr(8'h22, 8'hFF);
    rc("rssi_ro", 8'h22, 8'h3A);
    pulse(rx_enter);
    rc("rssi_inv", 8'h22, 8'h00);
    tally_and_finish();
  end
endmodule : rf_config_regs_tb
